// File: bench/pdw_far_model.sv
// far-side model: slow internal oscillator and pulled-up port A pins
`timescale 1ns/10ps
module pdw_far_model #(
  parameter int PORTA_W   = 8,
  parameter int SLOW_HALF = 40
) (
  // pin control from the bench
  input  wire logic [PORTA_W-1:0] pin_low,
  // towards the block
  output logic [PORTA_W-1:0]      porta_pins,
  output logic                    slow_osc_in
);
  // ==========================================================
  // oscillator
  // runs free and off the system clock phase, so halt or gating cannot stop it
  initial begin
    slow_osc_in = 1'b0;
    #3;
    forever #(SLOW_HALF) slow_osc_in = ~slow_osc_in;
  end

  // ==========================================================
  // pins
  // pull-ups: a released pin reads high, never the last driven level
  assign porta_pins = ~pin_low;
endmodule

// File: bench/pdw_top_tb.sv
// self-checking bench for the power-down and watchdog block
`timescale 1ns/10ps
module pdw_top_tb;
  import pdw_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, halt_exec, clear_watchdog_instr, idle_enable, stack_full;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, irq_req, irq_en, pin_low, porta_pins, d;
  logic       slow_osc_in, cpu_hold, resume_after_halt, irq_service_now, pc_sp_reset;
  logic       device_reset, sysclk_run, tbclk_run, lfclk_run, power_down_flag, wdt_expiry_flag;
  logic       seen;
  pdw_mode_e  pd_mode;
  pdw_mode_e  exp_mode [3] = '{PDW_SLEEP, PDW_IDLE_OFF, PDW_IDLE_ON};
  int         fail_count, n_tests, cyc, n;

  pdw_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
    .clear_watchdog_instr(clear_watchdog_instr), .idle_enable(idle_enable),
    .stack_full(stack_full), .cpu_hold(cpu_hold), .resume_after_halt(resume_after_halt),
    .irq_service_now(irq_service_now), .pc_sp_reset(pc_sp_reset),
    .device_reset(device_reset), .irq_req(irq_req), .irq_en(irq_en),
    .porta_pins(porta_pins), .slow_osc_in(slow_osc_in), .sysclk_run(sysclk_run),
    .tbclk_run(tbclk_run), .lfclk_run(lfclk_run), .pd_mode(pd_mode),
    .power_down_flag(power_down_flag), .wdt_expiry_flag(wdt_expiry_flag));
  pdw_far_model u_far (.pin_low(pin_low), .porta_pins(porta_pins), .slow_osc_in(slow_osc_in));

  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // longest path is two 2^8-tick timeouts plus three cleared periods, about 10k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("mismatch at %0t: run did not finish in time", $time);
      end_sim();
    end
  end

  // ==========================================================
  // tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic cpu_op(input logic h, input logic c, input logic ie);
    @(posedge clk);
    halt_exec            <= h;
    clear_watchdog_instr <= c;
    idle_enable          <= ie;
    @(posedge clk);
    halt_exec            <= 1'b0;
    clear_watchdog_instr <= 1'b0;
    #1;
  endtask
  task automatic set_in(input logic [7:0] pins, input logic [7:0] rq, input logic sf);
    @(posedge clk);
    pin_low    <= pins;
    irq_req    <= rq;
    stack_full <= sf;
  endtask
  // 0 resume, 1 service, 2 pc/stack reset, 3 device reset
  task automatic wait_evt(input int w, input int lim, output logic s, output int k);
    s = 1'b0;
    for (k = 0; k < lim && !s; k++) begin
      @(posedge clk);
      #1;
      case (w)
        0:       s = resume_after_halt;
        1:       s = irq_service_now;
        2:       s = pc_sp_reset;
        default: s = device_reset;
      endcase
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, halt_exec, clear_watchdog_instr, idle_enable, stack_full} = '0;
    {reg_addr, reg_wdata, irq_req, pin_low} = '0;
    irq_en = 8'hff;
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(PDW_ADDR_WDT_CTRL, d);  chk8(d, 8'h53);
    rd(PDW_ADDR_SYS_FLAGS, d); chk8(d, 8'h00);
    rd(PDW_ADDR_PD_STATUS, d); chk8(d, 8'h00);
    rd(4'h9, d);               chk8(d, 8'h00);
    wr(PDW_ADDR_SYS_FLAGS, 8'hff);
    rd(PDW_ADDR_SYS_FLAGS, d); chk8(d, 8'h80);
    for (int m = 0; m < 3; m++) begin
      wr(PDW_ADDR_SYS_FLAGS, {(m == 2), 7'h00});
      wr(PDW_ADDR_WAKE_MASK, 8'h01);
      cpu_op(1'b1, 1'b0, m != 0);
      chk8({6'h00, pd_mode}, {6'h00, exp_mode[m]});
      chk1(sysclk_run, m == 2);
      chk1(tbclk_run, m != 0);
      chk1(lfclk_run, 1'b1);
      chk1(cpu_hold, 1'b1);
      chk1(power_down_flag, 1'b1);
      chk1(wdt_expiry_flag, 1'b0);
      rd(PDW_ADDR_PD_STATUS, d); chk8(d, 8'h02);
      rd(PDW_ADDR_WAKE_MASK, d); chk8(d, 8'h01);
      set_in(8'h02, 8'h00, 1'b0);
      repeat (10) @(posedge clk);
      #1 chk1(cpu_hold, 1'b1);
      set_in(8'h03, 8'h00, 1'b0);
      wait_evt(0, 10, seen, n); chk1(seen, 1'b1);
      #1 chk1(cpu_hold, 1'b0);
      set_in(8'h00, 8'h00, 1'b0);
      repeat (5) @(posedge clk);
    end
    // interrupt wake: old request ignored, then serviced or deferred
    set_in(8'h00, 8'h02, 1'b0);
    cpu_op(1'b1, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    #1 chk1(cpu_hold, 1'b1);
    set_in(8'h00, 8'h06, 1'b0);
    wait_evt(1, 5, seen, n); chk1(seen, 1'b1);
    set_in(8'h00, 8'h00, 1'b1);
    cpu_op(1'b1, 1'b0, 1'b0);
    set_in(8'h00, 8'h08, 1'b1);
    wait_evt(0, 5, seen, n); chk1(seen, 1'b1);
    chk1(irq_service_now, 1'b0);
    // a disabled interrupt wakes but is not serviced
    @(posedge clk) irq_en <= 8'h00;
    set_in(8'h00, 8'h00, 1'b0);
    cpu_op(1'b1, 1'b0, 1'b0);
    set_in(8'h00, 8'h10, 1'b0);
    wait_evt(0, 5, seen, n); chk1(seen, 1'b1);
    chk1(irq_service_now, 1'b0);
    @(posedge clk) irq_en <= 8'hff;
    set_in(8'h00, 8'h00, 1'b0);
    // timeout during power-down at 2^8 ticks of 8 clk
    wr(PDW_ADDR_WDT_CTRL, 8'h50);
    cpu_op(1'b1, 1'b0, 1'b0);
    wait_evt(2, 3000, seen, n); chk1(seen, 1'b1);
    chk1(n >= 2028 && n <= 2070, 1'b1);
    chk1(wdt_expiry_flag, 1'b1);
    rd(PDW_ADDR_PD_STATUS, d); chk8(d, 8'h03);
    rd(PDW_ADDR_WDT_CTRL, d);  chk8(d, 8'h50);
    cpu_op(1'b0, 1'b1, 1'b0);
    rd(PDW_ADDR_PD_STATUS, d); chk8(d, 8'h01);
    // clears hold off the timeout, then it resets the device
    for (int i = 0; i < 3; i++) begin
      wait_evt(3, 1500, seen, n); chk1(seen, 1'b0);
      cpu_op(1'b0, 1'b1, 1'b0);
    end
    wait_evt(3, 2200, seen, n); chk1(seen, 1'b1);
    rd(PDW_ADDR_WDT_CTRL, d);  chk8(d, 8'h53);
    rd(PDW_ADDR_PD_STATUS, d); chk8(d & 8'h01, 8'h01);
    // invalid key
    wr(PDW_ADDR_WDT_CTRL, 8'h00);
    wait_evt(3, 40, seen, n); chk1(seen, 1'b1);
    chk1(n >= 6 && n <= 26, 1'b1);
    rd(PDW_ADDR_SYS_FLAGS, d); chk8(d & 8'h7f, 8'h01);
    rd(PDW_ADDR_WDT_CTRL, d);  chk8(d, 8'h53);
    wr(PDW_ADDR_SYS_FLAGS, 8'h01);
    rd(PDW_ADDR_SYS_FLAGS, d); chk8(d & 8'h01, 8'h01);
    wr(PDW_ADDR_SYS_FLAGS, 8'h00);
    rd(PDW_ADDR_SYS_FLAGS, d); chk8(d, 8'h00);
    end_sim();
  end
endmodule

// File: hdl/pdw_pkg.sv
// constants and types shared by the power-down and watchdog block
package pdw_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0] PDW_ADDR_WDT_CTRL  = 4'h0;
  localparam logic [3:0] PDW_ADDR_SYS_FLAGS = 4'h1;
  localparam logic [3:0] PDW_ADDR_WAKE_MASK = 4'h2;
  localparam logic [3:0] PDW_ADDR_PD_STATUS = 4'h3;

  // ==========================================================
  // watchdog control fields
  localparam logic [7:0] PDW_WDT_CTRL_RST = 8'h53;
  localparam int         PDW_KEY_MSB      = 7;
  localparam int         PDW_KEY_LSB      = 3;
  localparam int         PDW_SEL_MSB      = 2;
  localparam logic [4:0] PDW_KEY_GOOD_A   = 5'h15;
  localparam logic [4:0] PDW_KEY_GOOD_B   = 5'h0a;
  localparam logic [1:0] PDW_KEY_DEBOUNCE = 2'h2;
  localparam int         PDW_CNT_W        = 19;

  // ==========================================================
  // system flags fields
  localparam int         PDW_FLG_KEEP_SYSCLK = 7;
  localparam int         PDW_FLG_KEY_RESET   = 0;
  localparam logic       PDW_KEEP_SYSCLK_RST = 1'b0;

  // ==========================================================
  // power-down status fields
  localparam int         PDW_ST_PD_FLAG  = 1;
  localparam int         PDW_ST_EXP_FLAG = 0;

  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    PDW_RUN      = 2'b00,
    PDW_SLEEP    = 2'b01,
    PDW_IDLE_OFF = 2'b10,
    PDW_IDLE_ON  = 2'b11
  } pdw_mode_e;

endpackage

// File: hdl/pdw_top.sv
// power-down mode control and always-on watchdog
`timescale 1ns/10ps
module pdw_top #(
  parameter int PORTA_W = 8,
  parameter int IRQ_W   = 8
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  // cpu core
  input  wire logic                 halt_exec,
  input  wire logic                 clear_watchdog_instr,
  input  wire logic                 idle_enable,
  input  wire logic                 stack_full,
  output logic                      cpu_hold,
  output logic                      resume_after_halt,
  output logic                      irq_service_now,
  output logic                      pc_sp_reset,
  output logic                      device_reset,
  // interrupt controller
  input  wire logic [IRQ_W-1:0]     irq_req,
  input  wire logic [IRQ_W-1:0]     irq_en,
  // pins and clocks
  input  wire logic [PORTA_W-1:0]   porta_pins,
  input  wire logic                 slow_osc_in,
  output logic                      sysclk_run,
  output logic                      tbclk_run,
  output logic                      lfclk_run,
  // status
  output pdw_pkg::pdw_mode_e        pd_mode,
  output logic                      power_down_flag,
  output logic                      wdt_expiry_flag
);
  import pdw_pkg::*;

  // ==========================================================
  // functions
  function automatic logic key_ok(input logic [7:0] ctrl);
    key_ok = (ctrl[PDW_KEY_MSB:PDW_KEY_LSB] == PDW_KEY_GOOD_A) ||
             (ctrl[PDW_KEY_MSB:PDW_KEY_LSB] == PDW_KEY_GOOD_B);
  endfunction

  function automatic logic [4:0] period_bit(input logic [2:0] sel);
    case (sel)
      3'h0:    period_bit = 5'h08;
      3'h1:    period_bit = 5'h0a;
      3'h2:    period_bit = 5'h0c;
      3'h3:    period_bit = 5'h0e;
      3'h4:    period_bit = 5'h0f;
      3'h5:    period_bit = 5'h10;
      3'h6:    period_bit = 5'h11;
      default: period_bit = 5'h12;
    endcase
  endfunction

  // ==========================================================
  // state
  pdw_mode_e            mode;
  pdw_mode_e            next_mode;
  logic [7:0]           wdt_ctrl;
  logic                 keep_sysclk;
  logic                 key_flag;
  logic [PORTA_W-1:0]   wake_mask;
  logic [PDW_CNT_W-1:0] wdt_cnt;
  logic [PDW_CNT_W-1:0] next_cnt;
  logic [1:0]           key_dbc;
  logic [IRQ_W-1:0]     irq_at_entry;
  logic                 osc_s1;
  logic                 osc_s2;
  logic                 osc_s3;
  logic [PORTA_W-1:0]   pa_s1;
  logic [PORTA_W-1:0]   pa_s2;
  logic [PORTA_W-1:0]   pa_s3;

  logic                 slow_tick;
  logic                 wdt_to;
  logic                 key_trip;
  logic                 norm_to;
  logic                 reset_now;
  logic                 in_pd;
  logic                 enter_pd;
  logic                 pa_wake;
  logic [IRQ_W-1:0]     irq_new;
  logic                 irq_wake;
  logic                 irq_svc;
  logic                 pd_to;
  logic                 flags_wr;

  // ==========================================================
  // synchronisers; slow clock sampled as a level
  always_ff @(posedge clk) begin
    osc_s1 <= slow_osc_in;
    osc_s2 <= osc_s1;
    osc_s3 <= osc_s2;
    pa_s1  <= porta_pins;
    pa_s2  <= pa_s1;
    pa_s3  <= pa_s2;
  end

  // ==========================================================
  // combinational decode
  always_comb begin
    slow_tick = osc_s2 & ~osc_s3;
    next_cnt  = wdt_cnt + {{(PDW_CNT_W-1){1'b0}}, 1'b1};
    wdt_to    = slow_tick && next_cnt[period_bit(wdt_ctrl[PDW_SEL_MSB:0])];
    key_trip  = !key_ok(wdt_ctrl) && slow_tick && (key_dbc == PDW_KEY_DEBOUNCE - 2'h1);
    in_pd     = (mode != PDW_RUN);
    norm_to   = wdt_to && !in_pd;
    pd_to     = wdt_to && in_pd;
    reset_now = key_trip || norm_to;
    enter_pd  = !in_pd && halt_exec && !reset_now;
    pa_wake   = |(pa_s3 & ~pa_s2 & wake_mask);
    irq_new   = irq_req & ~irq_at_entry;
    irq_wake  = |irq_new;
    irq_svc   = (|(irq_new & irq_en)) && !stack_full;
    flags_wr  = reg_wr && (reg_addr == PDW_ADDR_SYS_FLAGS);
  end

  // ==========================================================
  // power-down mode selection and wake-up
  always_comb begin
    next_mode = mode;
    case (mode)
      PDW_RUN: begin
        if (enter_pd) begin
          if (!idle_enable)
            next_mode = PDW_SLEEP;
          else if (!keep_sysclk)
            next_mode = PDW_IDLE_OFF;
          else
            next_mode = PDW_IDLE_ON;
        end
      end
      PDW_SLEEP, PDW_IDLE_OFF, PDW_IDLE_ON: begin
        if (reset_now || pd_to || pa_wake || irq_wake)
          next_mode = PDW_RUN;
      end
      default: next_mode = PDW_RUN;
    endcase
  end

  // clock gates follow the mode; slow clock never stops so the watchdog lives on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode       <= PDW_RUN;
      pd_mode    <= PDW_RUN;
      cpu_hold   <= 1'b0;
      sysclk_run <= 1'b1;
      tbclk_run  <= 1'b1;
      lfclk_run  <= 1'b1;
    end else begin
      mode       <= next_mode;
      pd_mode    <= next_mode;
      cpu_hold   <= (next_mode != PDW_RUN);
      sysclk_run <= (next_mode == PDW_RUN) || (next_mode == PDW_IDLE_ON);
      tbclk_run  <= (next_mode != PDW_SLEEP);
      lfclk_run  <= 1'b1;
    end
  end

  // ==========================================================
  // wake-up and reset pulses to the core; on entry only irq_at_entry is loaded, from irq_req
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resume_after_halt <= 1'b0;
      irq_service_now   <= 1'b0;
      pc_sp_reset       <= 1'b0;
      device_reset      <= 1'b0;
      irq_at_entry      <= '0;
    end else begin
      device_reset      <= reset_now;
      pc_sp_reset       <= in_pd && pd_to && !key_trip;
      // service outranks port A, so a wake never raises both pulses
      irq_service_now   <= in_pd && !reset_now && !pd_to && irq_svc;
      resume_after_halt <= in_pd && !reset_now && !pd_to && !irq_svc &&
                           (pa_wake || irq_wake);
      if (enter_pd)
        irq_at_entry <= irq_req;
    end
  end

  // ==========================================================
  // watchdog counter: always enabled, no stop control exists
  always_ff @(posedge clk) begin
    if (!rst_n)
      wdt_cnt <= '0;
    else if (reset_now || enter_pd || clear_watchdog_instr || wdt_to)
      wdt_cnt <= '0;
    else if (slow_tick)
      wdt_cnt <= next_cnt;
  end

  // debounce counts slow ticks while the key is corrupt
  always_ff @(posedge clk) begin
    if (!rst_n || key_ok(wdt_ctrl) || key_trip)
      key_dbc <= 2'h0;
    else if (slow_tick)
      key_dbc <= key_dbc + 2'h1;
  end

  // ==========================================================
  // control register; power-down timeout leaves it alone
  always_ff @(posedge clk) begin
    if (!rst_n || reset_now)
      wdt_ctrl <= PDW_WDT_CTRL_RST;
    else if (reg_wr && reg_addr == PDW_ADDR_WDT_CTRL)
      wdt_ctrl <= reg_wdata;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      keep_sysclk <= PDW_KEEP_SYSCLK_RST;
      wake_mask   <= '0;
    end else begin
      if (flags_wr)
        keep_sysclk <= reg_wdata[PDW_FLG_KEEP_SYSCLK];
      if (reg_wr && reg_addr == PDW_ADDR_WAKE_MASK)
        wake_mask <= reg_wdata[PORTA_W-1:0];
    end
  end

  // set beats a software clear landing in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n)
      key_flag <= 1'b0;
    else if (key_trip)
      key_flag <= 1'b1;
    else if (flags_wr && !reg_wdata[PDW_FLG_KEY_RESET])
      key_flag <= 1'b0;
  end

  // ==========================================================
  // power-down and expiry flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_down_flag <= 1'b0;
      wdt_expiry_flag <= 1'b0;
    end else begin
      if (enter_pd) begin
        power_down_flag <= 1'b1;
        wdt_expiry_flag <= 1'b0;
      end else begin
        if (clear_watchdog_instr)
          power_down_flag <= 1'b0;
        if (wdt_to)
          wdt_expiry_flag <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read port; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!rst_n || !reg_rd)
      reg_rdata <= 8'h00;
    else begin
      case (reg_addr)
        PDW_ADDR_WDT_CTRL:  reg_rdata <= wdt_ctrl;
        PDW_ADDR_SYS_FLAGS: reg_rdata <= {keep_sysclk, 6'h00, key_flag};
        PDW_ADDR_WAKE_MASK: reg_rdata <= 8'(wake_mask);
        PDW_ADDR_PD_STATUS: reg_rdata <= {6'h00, power_down_flag, wdt_expiry_flag};
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence halt_taken_s;
    !in_pd && halt_exec && !reset_now;
  endsequence

  sequence wake_pd_to_s;
    in_pd && pd_to && !key_trip;
  endsequence

  sleep_entry_a: assert property (halt_taken_s and !idle_enable |=>
    pd_mode == PDW_SLEEP && !sysclk_run && !tbclk_run && cpu_hold && lfclk_run)
    else $error("sleep entry wrong");
  idle_off_entry_a: assert property (halt_taken_s and idle_enable && !keep_sysclk |=>
    pd_mode == PDW_IDLE_OFF && !sysclk_run && tbclk_run && cpu_hold)
    else $error("idle clock-off entry wrong");
  idle_on_entry_a: assert property (halt_taken_s and idle_enable && keep_sysclk |=>
    pd_mode == PDW_IDLE_ON && sysclk_run && tbclk_run && cpu_hold)
    else $error("idle clock-on entry wrong");
  entry_flags_a: assert property (halt_taken_s |=>
    power_down_flag && !wdt_expiry_flag && wdt_cnt == '0)
    else $error("entry flags or counter wrong");
  pd_timeout_wake_a: assert property (wake_pd_to_s |=>
    pc_sp_reset && wdt_expiry_flag && !device_reset && mode == PDW_RUN &&
    wdt_ctrl == $past(wdt_ctrl)) else $error("power-down timeout handling wrong");
  clear_pdf_a: assert property (clear_watchdog_instr && !enter_pd |=>
    !power_down_flag && wdt_cnt == '0) else $error("clear-watchdog missed");
  porta_wake_a: assert property (in_pd && pa_wake && !irq_svc &&
    !reset_now && !pd_to |=> resume_after_halt && !cpu_hold) else $error("port A wake missed");
  stale_irq_a: assert property (in_pd && !pa_wake && !pd_to && !reset_now &&
    ((irq_req & ~irq_at_entry) == '0) |=> cpu_hold)
    else $error("stale interrupt woke device");
  irq_service_a: assert property (in_pd && !reset_now && !pd_to &&
    |(irq_new & irq_en) && !stack_full |=> irq_service_now && !resume_after_halt)
    else $error("interrupt service missed");
  key_trip_a: assert property (key_trip |=>
    device_reset && key_flag && wdt_ctrl == PDW_WDT_CTRL_RST)
    else $error("key fault reset wrong");
  key_flag_hold_a: assert property (key_flag && !(flags_wr &&
    !reg_wdata[PDW_FLG_KEY_RESET]) |=> key_flag[*2] or (key_flag ##1 1'b1))
    else $error("key flag lost without write");
  normal_timeout_a: assert property (norm_to && !key_trip |=>
    device_reset && wdt_expiry_flag && wdt_ctrl == PDW_WDT_CTRL_RST)
    else $error("normal timeout reset wrong");
  flags_zero_a: assert property (reg_rd && reg_addr == PDW_ADDR_SYS_FLAGS |=>
    reg_rdata[6:3] == 4'h0) else $error("unimplemented flags bits not zero");

endmodule
